// *** core/asc_pkg.sv ***
`default_nettype none

package asc_pkg;

  // Clock and link timing
  localparam int CLK_NS       = 5;
  localparam int TOSC_NS      = 400;
  localparam int TRI_MIN_TOSC = 6;
  localparam int TRI_MAX_TOSC = 10;
  localparam int TRI_MIN_CYC  = (TRI_MIN_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRI_MAX_CYC  = (TRI_MAX_TOSC * TOSC_NS) / CLK_NS;
  // Midpoint gives margin against both edges of the window
  localparam int TRI_CYC      = (TRI_MIN_CYC + TRI_MAX_CYC) / 2;
  localparam int CNT_W        = 12;

  // Gaps the host must honour, in master clock or data-ready periods
  localparam int SCLK_MIN_TOSC     = 4;
  localparam int GAP_RW_TOSC       = 50;
  localparam int GAP_CSUM_TOSC     = 200;
  localparam int GAP_CSUM_ALL_TOSC = 1100;
  localparam int GAP_COPY_TOSC     = 220;
  localparam int GAP_COPY_ALL_TOSC = 1600;
  localparam int GAP_CAL_DATA_READY_N      = 7;
  localparam int GAP_FULL_CAL_DATA_READY_N = 14;
  localparam int GAP_RESET_TOSC    = 16;

  // Serial framing
  localparam int BYTE_W  = 8;
  localparam int SYNC_W  = 3;

  typedef enum logic [1:0] {
    ASC_PH_IDLE  = 2'b00,
    ASC_PH_SHIFT = 2'b01,
    ASC_PH_HOLD  = 2'b10
  } asc_phase_t;

  // Three-stage synchronisers, bit 0 is the first flop
  typedef struct packed {
    logic [SYNC_W-1:0] cs_n;
    logic [SYNC_W-1:0] sclk;
    logic [SYNC_W-1:0] din;
    logic [SYNC_W-1:0] clock_polarity_sel;
    logic [SYNC_W-1:0] rst_n;
    logic [SYNC_W-1:0] pdn_n;
    logic [SYNC_W-1:0] csync_n;
  } asc_pins_t;

endpackage : asc_pkg

`default_nettype wire

// *** core/asc_serial_port.sv ***
// Function
// - Output released 6-10 tosc after edge, or chip-select high.
// - Reset pin low returns everything to initial state.
// - Power-down low holds the serial engine idle; sync, data-ready set and command buffer drain still run.
// - Sync input low restarts conversion timing.
// - Serial port responds only while chip-select low.
// - Calibration done drives data-ready output low.
`timescale 1ns/1ps
`default_nettype none

module asc_serial_port #(
  parameter int DATA_W = asc_pkg::BYTE_W
) (
  // Clock, reset, enable
  input  wire logic              i_ref_clk,
  input  wire logic              i_srst,
  input  wire logic              i_clk_en,
  // Device pins
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_din,
  input  wire logic              i_clock_polarity_sel,
  input  wire logic              i_rst_n,
  input  wire logic              i_power_down_n,
  input  wire logic              i_conv_sync_n,
  output logic                   o_dout,
  output logic                   o_dout_oe,
  output logic                   o_data_ready_n,
  // Core events
  input  wire logic              i_cal_done,
  input  wire logic              i_result_ready,
  input  wire logic [DATA_W-1:0] i_tx_byte,
  output logic                   o_conv_restart,
  output logic                   o_power_down,
  // Received command bytes
  output logic                   o_cmd_valid,
  output logic [DATA_W-1:0]      o_cmd_byte,
  input  wire logic              i_cmd_ready,
  output logic                   o_cmd_overrun
);

  // Reject widths the bit counter cannot serve
  if (DATA_W != 8) begin : g_width_check
    $error("asc_serial_port: DATA_W must be 8");
  end

  typedef struct packed {
    asc_pkg::asc_pins_t          pins;
    logic                        cs_lvl;
    logic                        sclk_lvl;
    logic                        pdn_lvl;
    logic                        csync_lvl;
    asc_pkg::asc_phase_t         phase;
    logic [DATA_W-1:0]           rx_sh;
    logic [2:0]                  bit_cnt;
    logic [DATA_W-1:0]           tx_sh;
    logic                        tx_live;
    logic                        dout;
    logic                        oe;
    logic [asc_pkg::CNT_W-1:0]   idle_cnt;
    logic                        data_ready_n_n;
    logic                        restart;
    logic                        pdown;
    logic                        overrun;
    logic [1:0]                  fv;
    logic [1:0][DATA_W-1:0]      fdat;
  } asc_state_t;

  asc_state_t st_ff;
  asc_state_t nxt_st;

  // Idle levels: active-low pins read high, data-ready deasserted
  function automatic asc_state_t rst_val();
    asc_state_t r;
    r            = '0;
    r.pins.cs_n  = '1;
    r.pins.rst_n = '1;
    r.pins.pdn_n = '1;
    r.pins.csync_n = '1;
    r.cs_lvl     = 1'b1;
    r.pdn_lvl    = 1'b1;
    r.csync_lvl  = 1'b1;
    r.data_ready_n_n     = 1'b1;
    r.phase      = asc_pkg::ASC_PH_IDLE;
    return r;
  endfunction : rst_val

  logic pin_rst;
  logic sclk_chg;
  logic samp_edge;
  logic shift_edge;
  logic csync_fall;
  logic byte_done;

  // Edges count once stages two and three agree
  always_comb begin
    pin_rst    = !st_ff.pins.rst_n[1] && !st_ff.pins.rst_n[2];
    sclk_chg   = (st_ff.pins.sclk[1] == st_ff.pins.sclk[2]) &&
                 (st_ff.pins.sclk[2] != st_ff.sclk_lvl);
    samp_edge  = sclk_chg && (st_ff.pins.sclk[2] ^ st_ff.pins.clock_polarity_sel[2]) && !st_ff.cs_lvl;
    shift_edge = sclk_chg && !(st_ff.pins.sclk[2] ^ st_ff.pins.clock_polarity_sel[2]) && !st_ff.cs_lvl;
    csync_fall = (st_ff.pins.csync_n[1] == st_ff.pins.csync_n[2]) &&
                 !st_ff.pins.csync_n[2] && st_ff.csync_lvl;
    byte_done  = samp_edge && st_ff.pdn_lvl && (st_ff.bit_cnt == 3'h7);
  end

  // Next-state logic for the whole port
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pins.cs_n    = {st_ff.pins.cs_n[1:0], i_cs_n};
    nxt_st.pins.sclk    = {st_ff.pins.sclk[1:0], i_sclk};
    nxt_st.pins.din     = {st_ff.pins.din[1:0], i_din};
    nxt_st.pins.clock_polarity_sel     = {st_ff.pins.clock_polarity_sel[1:0], i_clock_polarity_sel};
    nxt_st.pins.rst_n   = {st_ff.pins.rst_n[1:0], i_rst_n};
    nxt_st.pins.pdn_n   = {st_ff.pins.pdn_n[1:0], i_power_down_n};
    nxt_st.pins.csync_n = {st_ff.pins.csync_n[1:0], i_conv_sync_n};
    nxt_st.restart = 1'b0;
    // Stable levels
    if (st_ff.pins.cs_n[1] == st_ff.pins.cs_n[2]) begin
      nxt_st.cs_lvl = st_ff.pins.cs_n[2];
    end
    if (st_ff.pins.pdn_n[1] == st_ff.pins.pdn_n[2]) begin
      nxt_st.pdn_lvl = st_ff.pins.pdn_n[2];
    end
    if (st_ff.pins.csync_n[1] == st_ff.pins.csync_n[2]) begin
      nxt_st.csync_lvl = st_ff.pins.csync_n[2];
    end
    if (sclk_chg) begin
      nxt_st.sclk_lvl = st_ff.pins.sclk[2];
    end
    if (csync_fall) begin
      nxt_st.restart = 1'b1;
    end
    // Command buffer drain; pop before push frees a slot
    if (i_cmd_ready && st_ff.fv[0]) begin
      nxt_st.fdat[0] = st_ff.fdat[1];
      nxt_st.fv      = {1'b0, st_ff.fv[1]};
    end
    nxt_st.pdown = !st_ff.pdn_lvl;
    if (!st_ff.pdn_lvl) begin
      // Whole serial engine held idle while powered down
      nxt_st.phase   = asc_pkg::ASC_PH_IDLE;
      nxt_st.bit_cnt = '0;
      nxt_st.tx_live = 1'b0;
      nxt_st.oe      = 1'b0;
      nxt_st.dout    = 1'b0;
    end else if (st_ff.cs_lvl) begin
      // Deselected: ignore clock, release output at once
      nxt_st.phase   = asc_pkg::ASC_PH_IDLE;
      nxt_st.bit_cnt = '0;
      nxt_st.tx_live = 1'b0;
      nxt_st.oe      = 1'b0;
    end else begin
      if (samp_edge) begin
        nxt_st.rx_sh   = {st_ff.rx_sh[DATA_W-2:0], st_ff.pins.din[2]};
        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
      end
      if (byte_done) begin
        nxt_st.tx_sh   = i_tx_byte;
        nxt_st.tx_live = 1'b1;
        if (nxt_st.fv[0] == 1'b0) begin
          nxt_st.fdat[0] = {st_ff.rx_sh[DATA_W-2:0], st_ff.pins.din[2]};
          nxt_st.fv[0]   = 1'b1;
        end else if (nxt_st.fv[1] == 1'b0) begin
          nxt_st.fdat[1] = {st_ff.rx_sh[DATA_W-2:0], st_ff.pins.din[2]};
          nxt_st.fv[1]   = 1'b1;
        end else begin
          // The host cannot be stalled, so a full buffer flags the loss
          nxt_st.overrun = 1'b1;
        end
      end
      if (shift_edge && st_ff.tx_live) begin
        nxt_st.oe    = 1'b1;
        nxt_st.dout  = st_ff.tx_sh[DATA_W-1];
        nxt_st.tx_sh = {st_ff.tx_sh[DATA_W-2:0], 1'b0};
      end else if (samp_edge && st_ff.tx_live) begin
        // A long host pause lets the timer release; drive the held bit again
        nxt_st.oe    = 1'b1;
      end
      // Release timer restarts on every serial clock edge
      if (sclk_chg) begin
        nxt_st.phase    = asc_pkg::ASC_PH_HOLD;
        nxt_st.idle_cnt = '0;
      end else begin
        case (st_ff.phase)
          asc_pkg::ASC_PH_HOLD: begin
            nxt_st.idle_cnt = st_ff.idle_cnt + asc_pkg::CNT_W'(1);
            if (st_ff.idle_cnt == asc_pkg::CNT_W'(asc_pkg::TRI_CYC - 1)) begin
              nxt_st.oe    = 1'b0;
              nxt_st.phase = asc_pkg::ASC_PH_IDLE;
            end
          end
          default: begin
            nxt_st.idle_cnt = '0;
          end
        endcase
      end
    end
    // Data-ready: new result or finished calibration wins over clear
    if (i_cal_done || i_result_ready) begin
      nxt_st.data_ready_n_n = 1'b0;
    end else if (samp_edge && st_ff.pdn_lvl) begin
      nxt_st.data_ready_n_n = 1'b1;
    end
    if (pin_rst) begin
      nxt_st = rst_val();
    end
  end

  // State register; enable low freezes everything
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_ff <= rst_val();
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state flops
  assign o_dout         = st_ff.dout;
  assign o_dout_oe      = st_ff.oe;
  assign o_data_ready_n = st_ff.data_ready_n_n;
  assign o_conv_restart = st_ff.restart;
  assign o_power_down   = st_ff.pdown;
  assign o_cmd_valid    = st_ff.fv[0];
  assign o_cmd_byte     = st_ff.fdat[0];
  assign o_cmd_overrun  = st_ff.overrun;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  cs_release_a: assert property (i_clk_en && st_ff.cs_lvl && !pin_rst |=> !o_dout_oe)
    else $error("output still driven while deselected");
  tri_late_a: assert property (o_dout_oe && st_ff.phase == asc_pkg::ASC_PH_HOLD
      |-> st_ff.idle_cnt <= asc_pkg::TRI_MAX_CYC)
    else $error("output held past release window");
  tri_early_a: assert property ($fell(o_dout_oe) && !$past(st_ff.cs_lvl)
      && $past(st_ff.pdn_lvl) && !$past(pin_rst)
      |-> $past(st_ff.idle_cnt) >= asc_pkg::TRI_MIN_CYC - 1)
    else $error("output released too early");
  pin_reset_a: assert property (i_clk_en && pin_rst
      |=> !o_dout_oe && o_data_ready_n && !o_cmd_valid && !o_cmd_overrun)
    else $error("reset pin did not clear state");
  power_down_a: assert property (i_clk_en && !st_ff.pdn_lvl && !pin_rst
      |=> o_power_down && !o_dout_oe)
    else $error("power-down not honoured");
  conv_sync_a: assert property (i_clk_en && csync_fall && !pin_rst
      |=> o_conv_restart ##1 (!o_conv_restart || !$past(i_clk_en)))
    else $error("sync low did not restart conversion");
  desel_quiet_a: assert property (i_clk_en && st_ff.cs_lvl && !pin_rst
      |=> st_ff.bit_cnt == 3'h0 && (!o_cmd_valid || $past(o_cmd_valid)))
    else $error("serial clock taken while deselected");
  cal_ready_a: assert property (i_clk_en && i_cal_done && !pin_rst |=> !o_data_ready_n)
    else $error("calibration end not flagged");
  rx_byte_a: assert property (i_clk_en && byte_done && !st_ff.fv[0] && !pin_rst
      |=> o_cmd_valid
          && o_cmd_byte == {$past(st_ff.rx_sh[DATA_W-2:0]), $past(st_ff.pins.din[2])})
    else $error("received byte not buffered");

  byte_rx_c: cover property (byte_done ##[1:1000] o_cmd_valid);
  tx_release_c: cover property ($rose(o_dout_oe) ##[1:1000] $fell(o_dout_oe));
  overrun_c: cover property ($rose(o_cmd_overrun));

endmodule : asc_serial_port

`default_nettype wire

// *** tb/asc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module asc_host_model (
  // Serial pins toward the device
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din,
  input  wire logic i_dout,
  input  wire logic i_dout_oe,
  input  wire logic i_pol
);
  logic last_ff;
  logic pin;

  // Half of the shortest legal serial clock period
  localparam int HALF_NS = 2 * asc_pkg::TOSC_NS;

  // A released line shows the inverse of its last value, not a stale copy
  assign pin = i_dout_oe ? i_dout : ~last_ff;

  // Track the last value driven by the device
  always @(i_dout or i_dout_oe) if (i_dout_oe) last_ff = i_dout;

  // Idle: deselected, clock parked low
  initial begin
    o_cs_n  = 1'b1;
    o_sclk  = 1'b0;
    o_din   = 1'b0;
    last_ff = 1'b0;
  end

  // Only data bytes go out, never copy or calibration opcodes,
  // so their long pauses never fall due
  // One byte in, then one byte out while a second byte goes in
  task xfer(input logic [7:0] tx0, input logic [7:0] tx1, output logic [7:0] rx);
    integer i;
    o_sclk = i_pol; // Park clock before selecting, so no stray edge
    #48 o_cs_n = 1'b0;
    #48;
    for (i = 7; i >= 0; i--) begin
      o_din = tx0[i];
      #(HALF_NS) o_sclk = ~i_pol;
      #(HALF_NS) o_sclk = i_pol;
    end
    // Pause before the output phase, clock parked
    #(asc_pkg::GAP_RW_TOSC * asc_pkg::TOSC_NS);
    for (i = 7; i >= 0; i--) begin
      o_din = tx1[i];
      #(HALF_NS) o_sclk = ~i_pol;
      #(HALF_NS - 2) rx[i] = pin; // Read late in the period, well after the shift edge
      #2 o_sclk = i_pol;
    end
    #48;
  endtask : xfer

  // End the frame
  task stop();
    o_cs_n = 1'b1;
  endtask : stop

  // Clock toggling while deselected must be ignored
  task idle_clocks();
    o_din = 1'b1;
    repeat (8) #24 o_sclk = ~o_sclk;
  endtask : idle_clocks
endmodule : asc_host_model

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0, srst = 1'b1, rst_n = 1'b1, pdn_n = 1'b1, sync_n = 1'b1, clock_polarity_sel = 1'b0;
  logic cal_done = 1'b0, res_rdy = 1'b0, rdy = 1'b0, en = 1'b1;
  logic [7:0] tx_byte = 8'hC3, rx, cbyte;
  wire logic cs_n, sclk, din, dout, oe, data_ready_n_n, restart, pdown, cvalid, overrun;
  int num_errors = 0, checked = 0, cycles = 0, n;
  longint t0;

  // 200 MHz reference clock
  always #2.5 clk = ~clk;

  asc_serial_port i_asc_serial_port (
    .i_ref_clk(clk), .i_srst(srst), .i_clk_en(en), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_din(din), .i_clock_polarity_sel(clock_polarity_sel), .i_rst_n(rst_n), .i_power_down_n(pdn_n),
    .i_conv_sync_n(sync_n), .o_dout(dout), .o_dout_oe(oe), .o_data_ready_n(data_ready_n_n),
    .i_cal_done(cal_done), .i_result_ready(res_rdy), .i_tx_byte(tx_byte),
    .o_conv_restart(restart), .o_power_down(pdown), .o_cmd_valid(cvalid),
    .o_cmd_byte(cbyte), .i_cmd_ready(rdy), .o_cmd_overrun(overrun));

  asc_host_model i_asc_host_model (
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout), .i_dout_oe(oe), .i_pol(clock_polarity_sel));

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  // Pop the buffer head after checking it
  task pop_check(input logic [7:0] exp);
    check(cbyte, exp);
    @(posedge clk) rdy <= 1'b1;
    @(posedge clk) rdy <= 1'b0;
    #1;
  endtask : pop_check

  task t_reset();
    @(posedge clk) srst <= 1'b1;
    cyc(16);
    @(posedge clk) srst <= 1'b0;
    #(asc_pkg::GAP_RESET_TOSC * asc_pkg::TOSC_NS);
    check(8'(oe), 8'h00);
    check(8'({data_ready_n_n, cvalid, overrun, pdown}), 8'h08);
    $display("test reset done");
  endtask : t_reset

  task t_xfer(input logic p);
    @(posedge clk) clock_polarity_sel <= p;
    cyc(8);
    i_asc_host_model.xfer(8'hA5, 8'h3C, rx);
    t0 = $time - 48;
    check(rx, 8'hC3);
    pop_check(8'hA5);
    pop_check(8'h3C);
    check(8'(cvalid), 8'h00);
    n = 0;
    while (oe === 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    n = int'(($time - t0) / asc_pkg::CLK_NS);
    check(8'(n >= asc_pkg::TRI_MIN_CYC && n <= asc_pkg::TRI_MAX_CYC), 8'h01);
    i_asc_host_model.stop();
    $display("test transfer done");
  endtask : t_xfer

  task t_overrun();
    i_asc_host_model.xfer(8'h11, 8'h22, rx);
    i_asc_host_model.xfer(8'h33, 8'h44, rx);
    i_asc_host_model.stop();
    cyc(8);
    check(8'(oe), 8'h00);
    check(8'(overrun), 8'h01);
    pop_check(8'h11);
    pop_check(8'h22);
    check(8'(cvalid), 8'h00);
    i_asc_host_model.idle_clocks();
    cyc(8);
    check(8'(cvalid), 8'h00);
    $display("test overrun done");
  endtask : t_overrun

  task t_ready();
    @(posedge clk) cal_done <= 1'b1;
    @(posedge clk) cal_done <= 1'b0;
    #1 check(8'(data_ready_n_n), 8'h00);
    i_asc_host_model.xfer(8'h5A, 8'h96, rx);
    i_asc_host_model.stop();
    cyc(8);
    check(8'(data_ready_n_n), 8'h01);
    pop_check(8'h5A);
    pop_check(8'h96);
    @(posedge clk) res_rdy <= 1'b1;
    @(posedge clk) res_rdy <= 1'b0;
    #1 check(8'(data_ready_n_n), 8'h00);
    $display("test ready done");
  endtask : t_ready

  task t_sync();
    // Enable low must freeze the sync path
    @(posedge clk) begin
      en     <= 1'b0;
      sync_n <= 1'b0;
    end
    n = 0;
    repeat (12) begin
      cyc(1);
      n += int'(restart);
    end
    check(8'(n), 8'h00);
    @(posedge clk) en <= 1'b1;
    n = 0;
    repeat (12) begin
      cyc(1);
      n += int'(restart);
    end
    check(8'(n), 8'h01);
    @(posedge clk) sync_n <= 1'b1;
    $display("test sync done");
  endtask : t_sync

  task t_pdown_rst();
    @(posedge clk) pdn_n <= 1'b0;
    cyc(8);
    check(8'(pdown), 8'h01);
    i_asc_host_model.xfer(8'h77, 8'h77, rx);
    i_asc_host_model.stop();
    cyc(8);
    check(8'(cvalid), 8'h00);
    @(posedge clk) pdn_n <= 1'b1;
    cyc(8);
    check(8'(pdown), 8'h00);
    i_asc_host_model.xfer(8'h9A, 8'h00, rx);
    i_asc_host_model.stop();
    cyc(8);
    check(8'(cvalid), 8'h01);
    pop_check(8'h9A);
    @(posedge clk) rst_n <= 1'b0;
    cyc(8);
    check(8'({data_ready_n_n, cvalid, overrun, oe}), 8'h08);
    @(posedge clk) rst_n <= 1'b1;
    #(asc_pkg::GAP_RESET_TOSC * asc_pkg::TOSC_NS);
    $display("test power down and pin reset done");
  endtask : t_pdown_rst

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    t_reset();
    t_xfer(1'b1);
    t_xfer(1'b0);
    t_overrun();
    t_ready();
    t_sync();
    t_pdown_rst();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
